// File: cocr_defines.vh
`ifndef COCR_DEFINES_VH
`define COCR_DEFINES_VH
// ==========================================================
// register offsets
`define COCR_ADDR_W          8
`define COCR_OFS_FMT_SLEEP   8'h06
`define COCR_OFS_ALARM_REF   8'h07
`define COCR_OFS_STATIC_HOLD 8'h08
`define COCR_OFS_AVG_TIME    8'h09
// ==========================================================
// reset values
`define COCR_RST_FMT_SLEEP   8'h2D
`define COCR_RST_ALARM_REF   8'h2A
`define COCR_RST_STATIC_HOLD 8'h00
`define COCR_RST_AVG_TIME    8'hC0
// ==========================================================
// writable bit masks
`define COCR_WMASK_FMT_SLEEP   8'h7F
`define COCR_WMASK_ALARM_REF   8'h07
`define COCR_WMASK_STATIC_HOLD 8'hF0
`define COCR_WMASK_AVG_TIME    8'hF8
// ==========================================================
// field positions
`define COCR_SLEEP_BIT  6
`define COCR_OUT2_FMT_HI 5
`define COCR_OUT2_FMT_LO 3
`define COCR_OUT1_FMT_HI 2
`define COCR_OUT1_FMT_LO 0
`define COCR_OUT2_HOLD_HI 7
`define COCR_OUT2_HOLD_LO 6
`define COCR_OUT1_HOLD_HI 5
`define COCR_OUT1_HOLD_LO 4
`define COCR_HIST_HI 7
`define COCR_HIST_LO 3
`define COCR_REF_HI 2
`define COCR_REF_LO 0
// ==========================================================
// format codes
`define COCR_FMT_DISABLE 3'h1
`define COCR_FMT_CMOS    3'h2
`define COCR_FMT_LSLVDS  3'h3
`define COCR_FMT_LVPECL  3'h5
`define COCR_FMT_CML     3'h6
`define COCR_FMT_LVDS    3'h7
// hold codes
`define COCR_HOLD_NORMAL 2'h0
`define COCR_HOLD_LOW    2'h1
`define COCR_HOLD_HIGH   2'h2
// reference codes
`define COCR_REF_EXT  3'h0
`define COCR_REF_IN1  3'h1
`define COCR_REF_IN2  3'h2
`endif

// File: cocr_out_gate.v
`include "cocr_defines.vh"
module cocr_out_gate
(
  // clock and reset
  input  wire       core_clk_i,
  input  wire       reset_i,
  // control
  input  wire [1:0] hold_sel_i,
  input  wire       off_i,
  // clocks
  input  wire       pll_clk_i,
  output reg        clk_o
);
  // ==========================================================
  // glitch-free hold
  // pll_clk_i is sampled on the core clock; changes only land on a
  // sampled edge that matches the held level, so no runt appears
  reg pll_q1;
  reg pll_q2;
  reg track;
  reg next_clk;
  reg next_track;
  always @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
    begin
      pll_q1 <= 1'b0;
      pll_q2 <= 1'b0;
      clk_o  <= 1'b0;
      track  <= 1'b0;
    end
    else
    begin
      pll_q1 <= pll_clk_i;
      pll_q2 <= pll_q1;
      clk_o  <= next_clk;
      track  <= next_track;
    end
  // after a hold or an off spell the output rejoins the source only once
  // both agree, so leaving a hold never cuts a pulse short
  always @*
  begin
    next_clk   = clk_o;
    next_track = 1'b0;
    if (off_i)
      next_clk = 1'b0;
    else if (hold_sel_i == `COCR_HOLD_LOW)
      next_clk = clk_o & pll_q2;  // see [R09]
    else if (hold_sel_i == `COCR_HOLD_HIGH)
      next_clk = clk_o | pll_q2;  // see [R09]
    else if (hold_sel_i == `COCR_HOLD_NORMAL && (track || pll_q2 == clk_o))
    begin
      next_clk   = pll_q2;  // see [R09]
      next_track = 1'b1;
    end
  end
endmodule // cocr_out_gate

// File: cocr_regs.v
// ==========================================================
// Overview of operation
// [R01] sleep bit set turns off both outputs and asserts power-down
// [R02] sleep overrides both output format selections
// [R03] out2 format: 001 off, 010 cmos, 011 lslvds, 101 pecl, 110 cml, 111 lvds
// [R04] out1 format: 001 off, 010 cmos, 011 lslvds, 101 pecl, 111 lvds
// [R05] software must not pair cmos format with bypass mode
// [R06] alarm reference: 000 external, 001 input one, 010 input two
// [R07] out2 hold: 00 normal, 01 static low, 10 static high
// [R08] out1 hold: 00 normal, 01 static low, 10 static high
// [R09] entering or leaving static hold makes no glitch or runt
// [R10] five-bit field sets history averaging time for digital hold
// [R11] digital hold keeps frequency from history, ignoring input quality
// [R12] reserved bits read reset value and ignore writes
`include "cocr_defines.vh"
module cocr_regs
(
  // clock and reset
  input  wire       core_clk_i,
  input  wire       reset_i,
  // register port
  input  wire [7:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  output reg        reg_rvalid_o,
  // clock sources
  input  wire       pll_clk_i,
  input  wire       force_holdover_i,
  // outputs
  output wire       clock_output_one_o,
  output wire       clock_output_two_o,
  output reg        sleep_pd_o,
  output reg  [2:0] out1_fmt_o,
  output reg        out1_en_o,
  output reg  [2:0] out2_fmt_o,
  output reg        out2_en_o,
  output reg  [1:0] offset_alarm_ref_sel_o,
  output reg        ref_valid_o,
  output reg  [4:0] history_avg_time_o,
  output reg        history_update_o
);
  // ==========================================================
  // register storage
  reg [7:0] output_format_sleep;
  reg [7:0] offset_alarm_reference;
  reg [7:0] output_static_hold;
  reg [7:0] history_averaging;
  // only writable bits change; reserved keep reset values
  always @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
    begin
      output_format_sleep    <= `COCR_RST_FMT_SLEEP;
      offset_alarm_reference <= `COCR_RST_ALARM_REF;
      output_static_hold     <= `COCR_RST_STATIC_HOLD;
      history_averaging      <= `COCR_RST_AVG_TIME;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `COCR_OFS_FMT_SLEEP:
          output_format_sleep <= (reg_wdata_i & `COCR_WMASK_FMT_SLEEP)
            | (`COCR_RST_FMT_SLEEP & ~`COCR_WMASK_FMT_SLEEP);  // see [R12]
        `COCR_OFS_ALARM_REF:
          offset_alarm_reference <= (reg_wdata_i & `COCR_WMASK_ALARM_REF)
            | (`COCR_RST_ALARM_REF & ~`COCR_WMASK_ALARM_REF);  // see [R12]
        `COCR_OFS_STATIC_HOLD:
          output_static_hold <= (reg_wdata_i & `COCR_WMASK_STATIC_HOLD)
            | (`COCR_RST_STATIC_HOLD & ~`COCR_WMASK_STATIC_HOLD);  // see [R12]
        `COCR_OFS_AVG_TIME:
          history_averaging <= (reg_wdata_i & `COCR_WMASK_AVG_TIME)
            | (`COCR_RST_AVG_TIME & ~`COCR_WMASK_AVG_TIME);  // see [R12]
        default:
          output_format_sleep <= output_format_sleep;
      endcase
    end
  // ==========================================================
  // read path, unmapped addresses read zero
  always @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
    begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          `COCR_OFS_FMT_SLEEP:   reg_rdata_o <= output_format_sleep;
          `COCR_OFS_ALARM_REF:   reg_rdata_o <= offset_alarm_reference;
          `COCR_OFS_STATIC_HOLD: reg_rdata_o <= output_static_hold;
          `COCR_OFS_AVG_TIME:    reg_rdata_o <= history_averaging;
          default:               reg_rdata_o <= 8'h00;
        endcase
      end
    end
  // ==========================================================
  // field decode
  wire       sleep_on = output_format_sleep[`COCR_SLEEP_BIT];
  wire [2:0] fmt1 = output_format_sleep[`COCR_OUT1_FMT_HI:`COCR_OUT1_FMT_LO];
  wire [2:0] fmt2 = output_format_sleep[`COCR_OUT2_FMT_HI:`COCR_OUT2_FMT_LO];
  wire [2:0] ref_sel = offset_alarm_reference[`COCR_REF_HI:`COCR_REF_LO];
  reg        next_en1;
  reg        next_en2;
  // reserved format codes leave the buffer off rather than guess
  always @*
  begin
    case (fmt1)  // see [R04]
      `COCR_FMT_CMOS, `COCR_FMT_LSLVDS, `COCR_FMT_LVPECL, `COCR_FMT_LVDS:
        next_en1 = 1'b1;
      default:
        next_en1 = 1'b0;
    endcase
    case (fmt2)  // see [R03]
      `COCR_FMT_CMOS, `COCR_FMT_LSLVDS, `COCR_FMT_LVPECL, `COCR_FMT_CML,
      `COCR_FMT_LVDS:
        next_en2 = 1'b1;
      default:
        next_en2 = 1'b0;
    endcase
    if (sleep_on)
    begin
      next_en1 = 1'b0;  // see [R02]
      next_en2 = 1'b0;  // see [R02]
    end
  end
  // ==========================================================
  // registered controls
  always @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
    begin
      sleep_pd_o             <= 1'b0;
      out1_fmt_o             <= 3'h0;
      out1_en_o              <= 1'b0;
      out2_fmt_o             <= 3'h0;
      out2_en_o              <= 1'b0;
      offset_alarm_ref_sel_o <= 2'h0;
      ref_valid_o            <= 1'b0;
      history_avg_time_o     <= 5'h00;
    end
    else
    begin
      sleep_pd_o <= sleep_on;  // see [R01]
      out1_fmt_o <= fmt1;
      out1_en_o  <= next_en1;
      out2_fmt_o <= fmt2;
      out2_en_o  <= next_en2;
      ref_valid_o <= (ref_sel == `COCR_REF_EXT) || (ref_sel == `COCR_REF_IN1)
        || (ref_sel == `COCR_REF_IN2);  // see [R06]
      offset_alarm_ref_sel_o <= ref_sel[1:0];  // see [R06]
      history_avg_time_o <= history_averaging[`COCR_HIST_HI:`COCR_HIST_LO];  // see [R10]
    end
  // ==========================================================
  // history update strobe
  // while in holdover or sleep the stored history is frozen; otherwise one
  // sample every 2^history_avg_time cycles, so the field sets the window
  parameter CNT_W = 32;
  reg [CNT_W-1:0] hist_cnt;
  wire [CNT_W-1:0] hist_span = {{(CNT_W-1){1'b0}}, 1'b1} << history_avg_time_o;
  always @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
    begin
      hist_cnt         <= {CNT_W{1'b0}};
      history_update_o <= 1'b0;
    end
    else if (force_holdover_i || sleep_pd_o)
    begin
      hist_cnt         <= {CNT_W{1'b0}};  // see [R11]
      history_update_o <= 1'b0;
    end
    else if (hist_cnt + {{(CNT_W-1){1'b0}}, 1'b1} >= hist_span)
    begin
      hist_cnt         <= {CNT_W{1'b0}};  // see [R10]
      history_update_o <= 1'b1;
    end
    else
    begin
      hist_cnt         <= hist_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      history_update_o <= 1'b0;
    end
  // ==========================================================
  // output clock gates
  wire [1:0] hold1 = output_static_hold[`COCR_OUT1_HOLD_HI:`COCR_OUT1_HOLD_LO];
  wire [1:0] hold2 = output_static_hold[`COCR_OUT2_HOLD_HI:`COCR_OUT2_HOLD_LO];
  cocr_out_gate u_gate1
  (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .hold_sel_i (hold1),  // see [R08]
    .off_i      (~out1_en_o),  // see [R01]
    .pll_clk_i  (pll_clk_i),
    .clk_o      (clock_output_one_o)
  );
  cocr_out_gate u_gate2
  (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .hold_sel_i (hold2),  // see [R07]
    .off_i      (~out2_en_o),  // see [R01]
    .pll_clk_i  (pll_clk_i),
    .clk_o      (clock_output_two_o)
  );
endmodule // cocr_regs

// File: cocr_regs_properties.sv
module cocr_regs_properties
(
  // clock and reset
  input wire       core_clk_i,
  input wire       reset_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire       reg_rvalid_o,
  // derived outputs
  input wire       sleep_pd_o,
  input wire [2:0] out1_fmt_o,
  input wire       out1_en_o,
  input wire [2:0] out2_fmt_o,
  input wire       out2_en_o,
  input wire [1:0] offset_alarm_ref_sel_o,
  input wire       ref_valid_o
);
  // ==========================================================
  // read port and register properties
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  chk_read_answer:
    assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  chk_rvalid_pulse:
    assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray read valid");
  chk_rdata_hold:
    assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
  chk_unmapped_zero:
    assert property (reg_rd_i && (reg_addr_i < 8'h06 || reg_addr_i > 8'h09)
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_ref_reserved:
    assert property (reg_rd_i && reg_addr_i == 8'h07 |=> reg_rdata_o[7:3] == 5'h05)
      else $error("reserved alarm ref bits changed");
  chk_hold_reserved:
    assert property (reg_rd_i && reg_addr_i == 8'h08 |=> reg_rdata_o[3:0] == 4'h0)
      else $error("reserved hold bits changed");
  chk_sleep_off:
    assert property (sleep_pd_o |-> !out1_en_o && !out2_en_o) else $error("output on in sleep");
  chk_out1_decode:
    assert property (out1_en_o == (!sleep_pd_o && out1_fmt_o inside {3'h2, 3'h3, 3'h5, 3'h7}))
      else $error("out1 enable decode wrong");
  chk_out2_decode:
    assert property (out2_en_o ==
      (!sleep_pd_o && out2_fmt_o inside {3'h2, 3'h3, 3'h5, 3'h6, 3'h7}))
      else $error("out2 enable decode wrong");
  chk_ref_valid:
    assert property (ref_valid_o |-> offset_alarm_ref_sel_o != 2'h3) else $error("bad ref valid");
endmodule // cocr_regs_properties

bind cocr_regs cocr_regs_properties i_cocr_regs_properties (.*);

// File: tb_cocr_regs.sv
`include "cocr_defines.vh"
`define chk_eq(n, e, g) \
  if ((g) !== (e)) \
  begin \
    $display("mismatch %s exp %h got %h", n, e, g); \
    mismatches++; \
  end \
  checks++;
module tb_cocr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk_i, reset_i, reg_wr_i, reg_rd_i, pll_clk_i, force_holdover_i;
  logic [7:0] reg_addr_i, reg_wdata_i, rdv, d;
  logic [7:0] shadow [6:9];
  wire  [7:0] reg_rdata_o;
  wire  [2:0] out1_fmt_o, out2_fmt_o;
  wire  [1:0] offset_alarm_ref_sel_o;
  wire  [4:0] history_avg_time_o;
  wire        reg_rvalid_o, clock_output_one_o, clock_output_two_o, sleep_pd_o;
  wire        out1_en_o, out2_en_o, ref_valid_o, history_update_o;
  int         mismatches, checks, h1, h2, a;
  cocr_regs i_cocr_regs (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .pll_clk_i(pll_clk_i),
    .force_holdover_i(force_holdover_i), .clock_output_one_o(clock_output_one_o),
    .clock_output_two_o(clock_output_two_o), .sleep_pd_o(sleep_pd_o), .out1_fmt_o(out1_fmt_o),
    .out1_en_o(out1_en_o), .out2_fmt_o(out2_fmt_o), .out2_en_o(out2_en_o),
    .offset_alarm_ref_sel_o(offset_alarm_ref_sel_o), .ref_valid_o(ref_valid_o),
    .history_avg_time_o(history_avg_time_o), .history_update_o(history_update_o));
  // ==========================================================
  // clocks; the source clock is slower so the resampled copy shows both levels
  initial
  begin
    core_clk_i = 0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    pll_clk_i = 0;
    forever #13 pll_clk_i = ~pll_clk_i;
  end
  // ==========================================================
  // expectation helpers and bus tasks
  function automatic logic [7:0] wm(input logic [7:0] ad);
    return ad == 8'h06 ? `COCR_WMASK_FMT_SLEEP : ad == 8'h07 ? `COCR_WMASK_ALARM_REF :
      ad == 8'h08 ? `COCR_WMASK_STATIC_HOLD : `COCR_WMASK_AVG_TIME;
  endfunction
  function automatic logic en_exp(input logic s, input logic [2:0] f, input logic two);
    return !s && (f == 3'h2 || f == 3'h3 || f == 3'h5 || f == 3'h7 || (two && f == 3'h6));
  endfunction
  task automatic print_verdict();
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge core_clk_i);
    reg_addr_i = ad;
    reg_wdata_i = dt;
    reg_wr_i = 1;
    @(negedge core_clk_i);
    reg_wr_i = 0;
    if (ad >= 8'h06 && ad <= 8'h09)
      shadow[ad] = (shadow[ad] & ~wm(ad)) | (dt & wm(ad));
  endtask
  task automatic rdchk(input logic [7:0] ad);
    int i;
    @(negedge core_clk_i);
    reg_addr_i = ad;
    reg_rd_i = 1;
    @(negedge core_clk_i);
    reg_rd_i = 0;
    for (i = 0; i < 8 && reg_rvalid_o !== 1'b1; i++) @(negedge core_clk_i);
    if (i == 8)
    begin
      mismatches++;
      print_verdict();
    end
    rdv = reg_rdata_o;
    `chk_eq("rdata", (ad >= 8'h06 && ad <= 8'h09) ? shadow[ad] : 8'h00, rdv)
  endtask
  task automatic watch(input int n);
    h1 = 0;
    h2 = 0;
    repeat (n)
    begin
      @(negedge core_clk_i);
      h1 += clock_output_one_o;
      h2 += clock_output_two_o;
    end
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    {reset_i, reg_addr_i, reg_wr_i, reg_rd_i, reg_wdata_i, force_holdover_i} = 20'h80000;
    {mismatches, checks} = 0;
    shadow[6] = `COCR_RST_FMT_SLEEP;
    shadow[7] = `COCR_RST_ALARM_REF;
    shadow[8] = `COCR_RST_STATIC_HOLD;
    shadow[9] = `COCR_RST_AVG_TIME;
    void'($urandom(77258));
    repeat (12) @(negedge core_clk_i);
    reset_i = 0;
    for (a = 4; a < 12; a++) rdchk(a);
    for (int c = 0; c < 16; c++)
    begin
      // no bypass mode in this block, so cmos codes are fair stimulus
      wr(8'h06, {1'($urandom), c[3], c[2:0], c[2:0]});
      repeat (2) @(negedge core_clk_i);
      `chk_eq("sleep", c[3], sleep_pd_o)
      `chk_eq("en1", en_exp(c[3], c[2:0], 0), out1_en_o)
      `chk_eq("en2", en_exp(c[3], c[2:0], 1), out2_en_o)
      rdchk(8'h06);
    end
    watch(20);
    `chk_eq("sleep clocks", 0, h1 + h2)
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h07, {5'($urandom), c[2:0]});
      repeat (2) @(negedge core_clk_i);
      `chk_eq("ref valid", c < 3, ref_valid_o)
      `chk_eq("ref sel", c[1:0], offset_alarm_ref_sel_o)
    end
    repeat (24)
    begin
      a = 4 + $urandom % 8;
      d = $urandom;
      wr(a, d);
      rdchk(a);
    end
    // random writes may have left sleep on, which would freeze the strobe
    wr(8'h06, 8'h3F);
    wr(8'h09, 8'h10);
    repeat (2) @(negedge core_clk_i);
    `chk_eq("hist", 5'h02, history_avg_time_o)
    a = 0;
    repeat (40)
    begin
      @(negedge core_clk_i);
      a += history_update_o;
    end
    `chk_eq("hist pulses", 10, a)
    force_holdover_i = 1;
    a = 0;
    repeat (40)
    begin
      @(negedge core_clk_i);
      a += history_update_o;
    end
    `chk_eq("hold pulses", 0, a)
    wr(8'h06, 8'h3F);
    for (int c = 0; c < 3; c++)
    begin
      wr(8'h08, c == 0 ? 8'h90 : c == 1 ? 8'h60 : 8'h0F);
      repeat (10) @(negedge core_clk_i);
      watch(30);
      // a running clock shows both levels; in the normal pass (c == 2) any mix counts as running
      if (c == 2 && h1 > 0 && h1 < 30)
        h1 = 15;
      if (c == 2 && h2 > 0 && h2 < 30)
        h2 = 15;
      `chk_eq("clk1", c == 0 ? 0 : c == 1 ? 30 : 15, h1)
      `chk_eq("clk2", c == 0 ? 30 : c == 1 ? 0 : 15, h2)
    end
    rdchk(8'h08);
    print_verdict();
  end
endmodule // tb_cocr_regs
